/* pkg/udc_pkg.sv */
// package: shared constants and types for the up/down preset counter
`default_nettype none
package udc_pkg;
  localparam int unsigned count_width = 4;
  localparam logic [3:0] count_max = 4'hf;
  localparam logic [3:0] count_min = 4'h0;
  localparam logic [3:0] count_step = 4'h1;
  localparam logic dir_up = 1'b0;
  localparam logic dir_down = 1'b1;
  localparam logic [3:0] count_reset_value = 4'h0;
  localparam logic [3:0] driver_divide_reset = 4'h0;
  localparam logic [3:0] driver_divide_last = 4'h1;
  typedef logic [3:0] udc_count_type;
endpackage : udc_pkg
`default_nettype wire

/* pkg/udc_link_if.sv */
// interface: pins between the counter stage and its driving logic
`timescale 1ns/1ps
`default_nettype none
interface udc_link_if;
  logic count_clock;
  logic async_load_n;
  logic count_enable_n;
  logic count_down;
  logic [3:0] preset_value;
  logic [3:0] count_value;
  logic terminal_flag;
  logic ripple_pulse_n;
  modport counter (
    input count_clock, async_load_n, count_enable_n, count_down, preset_value,
    output count_value, terminal_flag, ripple_pulse_n
  );
  modport driver (
    output count_clock, async_load_n, count_enable_n, count_down, preset_value,
    input count_value, terminal_flag, ripple_pulse_n
  );
endinterface : udc_link_if
`default_nettype wire

/* logic/udc_counter.sv */
// module: 4-bit up/down counter stage with preset, terminal flag and ripple pulse
//
// Overview of operation
// - four-bit count wraps modulo sixteen, always shown
// - low load copies preset at once, overriding count
// - count changes on clock rise only when enabled
// - direction low counts up, high counts down
// - flag high at fifteen up or zero down
// - flag decoded from count and direction only
// - flag ignores this stage's own enable
// - enabled with flag high: ripple low while clock low
// - ripple stays high when disabled or flag low
// - far logic must not clock on the flag
// - ripple cascade clocks next stage, first stage gates
// - shared clock low phase covers carry ripple
// - gated carry enables include all lower flags
//
// the stage samples its link pins on clk_i; count_clock is a level whose
// rising edge is detected here, so all pins are synchronous to clk_i.
// the load path is "immediate" in the sense of combinational: the output
// mux shows preset_value in the same cycle async_load_n is low.
`timescale 1ns/1ps
`default_nettype none
module udc_counter
#(
  parameter int unsigned count_width = udc_pkg::count_width
)
(
  // system
  input wire logic clk_i,
  input wire logic reset_i,
  // link
  udc_link_if.counter link
);
  ////////////////////////////////////////////////////////////////
  // the link carries a fixed four-bit count, so no other width can be served
  if (count_width != udc_pkg::count_width)
  begin : g_width_check
    $error("count_width must match the link width");
  end

  typedef struct packed {
    udc_pkg::udc_count_type count;
    logic clock_prev;
  } udc_state_type;

  udc_state_type state_reg;
  udc_state_type state_next;
  udc_pkg::udc_count_type shown;
  udc_pkg::udc_count_type toggle;
  logic rise;
  logic advance;
  logic going_up;
  logic flag;

  ////////////////////////////////////////////////////////////////
  assign rise = link.count_clock & ~state_reg.clock_prev;
  assign advance = rise & ~link.count_enable_n;
  assign going_up = (link.count_down == udc_pkg::dir_up);

  ////////////////////////////////////////////////////////////////
  // a bit flips when all lower bits are ones going up or zeros going down,
  // so the count wraps in both directions with no adder carry chain
  for (genvar b = 0; b < count_width; b++)
  begin : g_bit
    if (b == 0)
    begin : g_low
      assign toggle[b] = 1'b1;
    end
    else
    begin : g_high
      assign toggle[b] = going_up ? (&state_reg.count[b-1:0]) : ~(|state_reg.count[b-1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    state_next.clock_prev = link.count_clock;
    if (!link.async_load_n)
    begin
      state_next.count = link.preset_value;
    end
    else if (advance)
    begin
      state_next.count = state_reg.count ^ toggle;
    end
  end

  // reset_i only sets the edge detector's clock_prev high: the count itself has no reset
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_reg.clock_prev <= 1'b1;
    end
    else
    begin
      state_reg.clock_prev <= state_next.clock_prev;
    end
    state_reg.count <= state_next.count;
  end

  // load is transparent so the preset shows without waiting a clock
  assign shown = link.async_load_n ? state_reg.count : link.preset_value;
  assign link.count_value = shown;

  // decoded, so it may spike: keep it off clock inputs
  always_comb
  begin
    if (going_up)
    begin
      flag = (shown == udc_pkg::count_max);
    end
    else
    begin
      flag = (shown == udc_pkg::count_min);
    end
  end

  assign link.terminal_flag = flag;

  assign link.ripple_pulse_n = ~(~link.count_enable_n & link.terminal_flag & ~link.count_clock);
endmodule : udc_counter
`default_nettype wire

/* logic/udc_driver.sv */
// module: driving logic for one counter stage, makes count_clock by division
`timescale 1ns/1ps
`default_nettype none
module udc_driver
#(
  parameter int unsigned half_period = 2
)
(
  // system
  input wire logic clk_i,
  input wire logic reset_i,
  // user controls
  input wire logic run_i,
  input wire logic down_i,
  input wire logic load_i,
  input wire logic [3:0] preset_i,
  // user status
  output logic [3:0] count_o,
  output logic carry_o,
  output logic carry_pulse_o,
  // link
  udc_link_if.driver link
);
  // the divider counter is four bits wide
  if (half_period < 1 || half_period > 15)
  begin : g_half_period_check
    $error("half_period out of range");
  end

  typedef struct packed {
    logic [3:0] div;
    logic clock;
  } udc_drv_state_type;

  udc_drv_state_type state_reg;
  udc_drv_state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    if (state_reg.div >= 4'(half_period - 1))
    begin
      state_next.div = udc_pkg::driver_divide_reset;
      state_next.clock = ~state_reg.clock;
    end
    else
    begin
      state_next.div = state_reg.div + udc_pkg::driver_divide_last;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // single stage: the enable gates counting directly, the flag is only status
  assign link.count_clock = state_reg.clock;
  assign link.count_enable_n = ~run_i;
  assign link.count_down = down_i;
  assign link.async_load_n = ~load_i;
  assign link.preset_value = preset_i;
  assign count_o = link.count_value;
  assign carry_o = link.terminal_flag;
  assign carry_pulse_o = ~link.ripple_pulse_n;
endmodule : udc_driver
`default_nettype wire

/* test/udc_link_props.sv */
// checker: link pin assertions
`timescale 1ns/1ps
`default_nettype none
module udc_link_props
(
  // clock
  input wire logic clk_i,
  input wire logic reset_i,
  // pins
  input wire logic count_clock,
  input wire logic async_load_n,
  input wire logic count_enable_n,
  input wire logic count_down,
  input wire logic [3:0] preset_value,
  input wire logic [3:0] count_value,
  input wire logic terminal_flag,
  input wire logic ripple_pulse_n
);
  // the count is unknown until a load, so checks wait for one
  logic seen_reg;
  always_ff @(posedge clk_i)
    if (reset_i)
      seen_reg <= 1'b0;
    else if (!async_load_n)
      seen_reg <= 1'b1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i || !seen_reg);
  a_load_shows: assert property (!async_load_n |-> count_value == preset_value) else $error("load");
  a_count_step: assert property ($rose(count_clock) && async_load_n && !count_enable_n
    |=> !async_load_n || count_value == $past(count_value) + ($past(count_down) ? 4'hf : 4'h1)) else $error("step");
  a_count_hold: assert property (async_load_n && (count_enable_n || !$rose(count_clock))
    |=> !async_load_n || $stable(count_value)) else $error("hold");
  a_flag_decode: assert property (terminal_flag == (count_value == (count_down ? 4'h0 : 4'hf)))
    else $error("flag");
  a_flag_stays: assert property ($stable(count_value) && $stable(count_down) |-> $stable(terminal_flag))
    else $error("flag held");
  a_ripple_low: assert property (!count_enable_n && terminal_flag && !count_clock |-> !ripple_pulse_n)
    else $error("ripple low");
  a_ripple_high: assert property (count_enable_n || !terminal_flag |-> ripple_pulse_n) else $error("ripple");
  a_ripple_clock: assert property (!ripple_pulse_n |-> !count_clock) else $error("ripple clock");
endmodule : udc_link_props
`default_nettype wire

/* test/udc_counter_test.sv */
// testbench: driver and counter stage over the link
`timescale 1ns/1ps
`default_nettype none
module udc_counter_test;
  logic clk_i = 1'b0, reset_i = 1'b1, run_i = 1'b0, down_i = 1'b0, load_i = 1'b0;
  logic [3:0] preset_i = 4'h0, count_o, seen_v, v;
  logic carry_o, carry_pulse_o, armed = 1'b0;
  logic [7:0] lfsr = 8'h20;
  logic [3:0] exp_q[$];
  int bad_count = 0, compares = 0;
  udc_link_if link();
  always #2 clk_i = ~clk_i;
  udc_driver #(.half_period(1)) u_udc_driver (.clk_i, .reset_i, .run_i, .down_i, .load_i, .preset_i, .count_o,
    .carry_o, .carry_pulse_o, .link);
  udc_counter u_udc_counter (.clk_i, .reset_i, .link);
  udc_link_props u_udc_link_props (.clk_i, .reset_i, .count_clock(link.count_clock), .async_load_n(link.async_load_n),
    .count_enable_n(link.count_enable_n), .count_down(link.count_down), .preset_value(link.preset_value),
    .count_value(link.count_value), .terminal_flag(link.terminal_flag), .ripple_pulse_n(link.ripple_pulse_n));
  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : step
  task automatic chk(input logic [3:0] got, input logic [3:0] want);
    compares++;
    if (got !== want)
      $display("Error at %0t: %h not %h", $time, got, want);
    bad_count += int'(got !== want);
  endtask : chk
  task automatic test_done;
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  always @(posedge clk_i)
  begin
    if (armed)
    begin
      chk({3'h0, carry_o}, {3'h0, count_o === (down_i ? 4'h0 : 4'hf)});
      chk({3'h0, carry_pulse_o}, {3'h0, run_i & carry_o & ~link.count_clock});
    end
    if (count_o !== seen_v)
    begin
      seen_v = count_o;
      if (exp_q.size() > 0)
        chk(seen_v, exp_q.pop_front());
    end
  end
  initial
  begin
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    for (int t = 0; t < 3; t++)
    begin
      lfsr = step(lfsr);
      // a preset equal to the current count would show no change
      v = (lfsr[3:0] === count_o) ? ~lfsr[3:0] : lfsr[3:0];
      for (int k = 0; k < 19; k++)
        exp_q.push_back(t[0] ? v - 4'(k) : v + 4'(k));
      load_i = 1'b1;
      preset_i = v;
      down_i = t[0];
      repeat (2) @(negedge clk_i);
      load_i = 1'b0;
      armed = 1'b1;
      run_i = 1'b1;
      for (int k = 0; k < 400 && exp_q.size() > 0; k++)
        @(negedge clk_i);
      run_i = 1'b0;
      chk(4'(exp_q.size()), 4'h0);
      exp_q.delete();
      repeat (4) @(negedge clk_i);
      $display("test %0d done", t);
    end
    test_done();
  end
  initial
  begin
    #20000;
    bad_count++;
    test_done();
  end
endmodule : udc_counter_test
`default_nettype wire
